// *** hdl/arw_pkg.sv ***
// Package for the converter result and window register block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package arw_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_DEBUG_CONTROL  = 8'h0c;
  localparam logic [7:0] IDX_BYTE_STAGING   = 8'h0d;
  localparam logic [7:0] IDX_RESULT_LOW     = 8'h10;
  localparam logic [7:0] IDX_RESULT_HIGH    = 8'h11;
  localparam logic [7:0] IDX_WIN_LOW_LOW    = 8'h12;
  localparam logic [7:0] IDX_WIN_LOW_HIGH   = 8'h13;
  localparam logic [7:0] IDX_WIN_HIGH_LOW   = 8'h14;
  localparam logic [7:0] IDX_WIN_HIGH_HIGH  = 8'h15;
  localparam logic [7:0] IDX_WINDOW_MODE    = 8'h04;
  localparam logic [7:0] IDX_INT_MASK       = 8'h0a;
  localparam logic [7:0] IDX_INT_STATUS     = 8'h0b;
  localparam int         ADDR_LSB           = 2;
  localparam int         ADDR_W             = 10;

  // ****************************************************************
  // Fields and values
  // ****************************************************************
  localparam int          RUN_IN_DEBUG_BIT  = 0;
  localparam int          FLAG_READY_BIT    = 0;
  localparam int          FLAG_MATCH_BIT    = 1;
  localparam logic [9:0]  SAMPLE_MAX        = 10'h3ff;
  localparam logic [9:0]  SAMPLE_MIN        = 10'h000;
  localparam logic [15:0] ACC_CEILING       = 16'hffc0;
  localparam logic [6:0]  ACC_MAX_SAMPLES   = 7'h40;
  localparam logic [7:0]  BYTE_RESET        = 8'h00;
  localparam logic [15:0] WORD_RESET        = 16'h0000;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [2:0]
  {
    WIN_NONE    = 3'h0,
    WIN_BELOW   = 3'h1,
    WIN_ABOVE   = 3'h2,
    WIN_INSIDE  = 3'h3,
    WIN_OUTSIDE = 3'h4
  } arw_win_mode_t;

  // Converter sample input group
  typedef struct packed
  {
    logic       valid;
    logic       over_ref;
    logic       under_zero;
    logic       last;
    logic [9:0] code;
  } arw_sample_t;

endpackage

// *** hdl/arw_regs.sv ***
// Result, window threshold, staging and debug-run registers of the converter tail.
// Assumes one clock, synchronous low reset, an AXI4-Lite master and same-clock sample input.
`timescale 1ns/1ps

module arw_regs
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Converter side
  input  wire arw_pkg::arw_sample_t  sample_in,
  input  wire logic                  cpu_halted,
  output logic                       conv_enable,
  output logic                       irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] clamp_sample(input arw_pkg::arw_sample_t s);
    if (s.over_ref)
      clamp_sample = arw_pkg::SAMPLE_MAX;
    else if (s.under_zero)
      clamp_sample = arw_pkg::SAMPLE_MIN;
    else
      clamp_sample = s.code;
  endfunction

  function automatic logic win_match(input logic [2:0] mode, input logic [15:0] v,
                                     input logic [15:0] lo, input logic [15:0] hi);
    // Unsigned compares keep straight binary ordering
    unique case (mode)
      arw_pkg::WIN_BELOW:   win_match = v < lo;
      arw_pkg::WIN_ABOVE:   win_match = v > hi;
      arw_pkg::WIN_INSIDE:  win_match = (v > lo) && (v < hi);
      arw_pkg::WIN_OUTSIDE: win_match = (v < lo) || (v > hi);
      default:              win_match = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WRSP = 3'b010,
    ST_RRSP = 3'b100
  } arw_bus_state_t;

  logic [2:0]  wst_reg, wst_next;
  logic [2:0]  rst_reg, rst_next;
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [9:0]  awaddr_reg, awaddr_next;
  logic [7:0]  wbyte_reg, wbyte_next;
  logic        wlane_reg, wlane_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        dbg_reg, dbg_next;
  logic [7:0]  stage_reg, stage_next;
  logic [15:0] result_reg, result_next;
  logic [15:0] acc_reg, acc_next;
  logic [6:0]  cnt_reg, cnt_next;
  logic [15:0] winlo_reg, winlo_next;
  logic [15:0] winhi_reg, winhi_next;
  logic [2:0]  mode_reg, mode_next;
  logic [1:0]  flags_reg, flags_next;
  logic [1:0]  mask_reg, mask_next;
  logic        irq_reg, irq_next;
  logic        run_reg, run_next;
  logic        awrdy_reg, awrdy_next;
  logic        wrdy_reg, wrdy_next;

  localparam int ADDR_HI = arw_pkg::ADDR_LSB + 7;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [7:0]  widx;
    logic [7:0]  ridx;
    logic        do_wr;
    logic        do_rd;
    logic        running;
    logic [16:0] sum;
    logic [15:0] final_val;
    logic [1:0]  set_f;
    logic [1:0]  clr_f;
    widx        = awaddr_reg[ADDR_HI:arw_pkg::ADDR_LSB];
    ridx        = s_axi_araddr[ADDR_HI:arw_pkg::ADDR_LSB];
    do_wr       = 1'b0;
    do_rd       = 1'b0;
    sum         = 17'h00000;
    final_val   = 16'h0000;
    set_f       = 2'b00;
    clr_f       = 2'b00;
    running     = dbg_reg || !cpu_halted;
    wst_next    = wst_reg;
    rst_next    = rst_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wbyte_next  = wbyte_reg;
    wlane_next  = wlane_reg;
    bresp_next  = bresp_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    dbg_next    = dbg_reg;
    stage_next  = stage_reg;
    result_next = result_reg;
    acc_next    = acc_reg;
    cnt_next    = cnt_reg;
    winlo_next  = winlo_reg;
    winhi_next  = winhi_reg;
    mode_next   = mode_reg;
    mask_next   = mask_reg;

    // Write channel: address and data taken in either order
    unique case (wst_reg)
      ST_IDLE:
      begin
        if (s_axi_awvalid && !aw_got_reg)
        begin
          aw_got_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg)
        begin
          w_got_next = 1'b1;
          wbyte_next = s_axi_wdata[7:0];
          wlane_next = s_axi_wstrb[0];
        end
        if (aw_got_reg && w_got_reg)
        begin
          do_wr       = wlane_reg;
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
          bresp_next  = arw_pkg::RESP_OKAY;
          wst_next    = ST_WRSP;
        end
      end
      ST_WRSP:
        if (s_axi_bready)
          wst_next = ST_IDLE;
      default:
        wst_next = ST_IDLE;
    endcase

    // Register writes; byte lane 0 carries the data
    if (do_wr)
    begin
      unique case (widx)
        arw_pkg::IDX_DEBUG_CONTROL: dbg_next = wbyte_reg[arw_pkg::RUN_IN_DEBUG_BIT];
        arw_pkg::IDX_BYTE_STAGING:  stage_next = wbyte_reg;
        arw_pkg::IDX_WIN_LOW_LOW:   stage_next = wbyte_reg;
        arw_pkg::IDX_WIN_LOW_HIGH:  winlo_next = {wbyte_reg, stage_reg};
        arw_pkg::IDX_WIN_HIGH_LOW:  stage_next = wbyte_reg;
        arw_pkg::IDX_WIN_HIGH_HIGH: winhi_next = {wbyte_reg, stage_reg};
        arw_pkg::IDX_WINDOW_MODE:   mode_next = wbyte_reg[2:0];
        arw_pkg::IDX_INT_MASK:      mask_next = wbyte_reg[1:0];
        arw_pkg::IDX_INT_STATUS:    clr_f = wbyte_reg[1:0];
        default:                    bresp_next = arw_pkg::RESP_SLVERR;
      endcase
    end
    else if (wst_reg == ST_IDLE && aw_got_reg && w_got_reg)
    begin
      bresp_next = arw_pkg::RESP_OKAY;
    end

    // Read channel
    unique case (rst_reg)
      ST_IDLE:
        if (s_axi_arvalid)
        begin
          do_rd      = 1'b1;
          rst_next   = ST_RRSP;
          rresp_next = arw_pkg::RESP_OKAY;
          rdata_next = 32'h00000000;
        end
      ST_RRSP:
        if (s_axi_rready)
          rst_next = ST_IDLE;
      default:
        rst_next = ST_IDLE;
    endcase

    if (do_rd)
    begin
      unique case (ridx)
        arw_pkg::IDX_DEBUG_CONTROL: rdata_next[0] = dbg_reg;
        arw_pkg::IDX_BYTE_STAGING:  rdata_next[7:0] = stage_reg;
        arw_pkg::IDX_RESULT_LOW:
        begin
          rdata_next[7:0] = result_reg[7:0];
          stage_next      = result_reg[15:8];
          clr_f           = 2'b11;
        end
        arw_pkg::IDX_RESULT_HIGH:   rdata_next[7:0] = stage_reg;
        arw_pkg::IDX_WIN_LOW_LOW:   rdata_next[7:0] = winlo_reg[7:0];
        arw_pkg::IDX_WIN_LOW_HIGH:  rdata_next[7:0] = winlo_reg[15:8];
        arw_pkg::IDX_WIN_HIGH_LOW:  rdata_next[7:0] = winhi_reg[7:0];
        arw_pkg::IDX_WIN_HIGH_HIGH: rdata_next[7:0] = winhi_reg[15:8];
        arw_pkg::IDX_WINDOW_MODE:   rdata_next[2:0] = mode_reg;
        arw_pkg::IDX_INT_MASK:      rdata_next[1:0] = mask_reg;
        arw_pkg::IDX_INT_STATUS:    rdata_next[1:0] = flags_reg;
        default:                    rresp_next = arw_pkg::RESP_SLVERR;
      endcase
    end

    // Converter tail: halted in debug unless the run bit is set
    run_next = running;
    if (running && sample_in.valid)
    begin
      sum = {1'b0, acc_reg} + {7'h00, clamp_sample(sample_in)};
      // At most 64 samples of 0x3ff, so the sum stays within 0xffc0
      if (sum > {1'b0, arw_pkg::ACC_CEILING})
        sum = {1'b0, arw_pkg::ACC_CEILING};
      if (sample_in.last || (cnt_reg + 7'h01) >= arw_pkg::ACC_MAX_SAMPLES)
      begin
        final_val   = sum[15:0];
        result_next = final_val;
        acc_next    = arw_pkg::WORD_RESET;
        cnt_next    = 7'h00;
        set_f[arw_pkg::FLAG_READY_BIT] = 1'b1;
        set_f[arw_pkg::FLAG_MATCH_BIT] = win_match(mode_reg, final_val, winlo_reg, winhi_reg);
      end
      else
      begin
        acc_next = sum[15:0];
        cnt_next = cnt_reg + 7'h01;
      end
    end

    // Set wins over clear
    flags_next = (flags_reg & ~clr_f) | set_f;
    irq_next   = |(flags_next & mask_next);
  end

  // ****************************************************************
  // Handshake ready flops
  // ****************************************************************
  // Computed from next state so the ready timing stays unchanged
  always_comb
  begin
    awrdy_next = (wst_next == ST_IDLE) && !aw_got_next;
    wrdy_next  = (wst_next == ST_IDLE) && !w_got_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awrdy_reg <= 1'b1;
      wrdy_reg  <= 1'b1;
    end
    else
    begin
      awrdy_reg <= awrdy_next;
      wrdy_reg  <= wrdy_next;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wst_reg    <= ST_IDLE;
      rst_reg    <= ST_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 10'h000;
      wbyte_reg  <= arw_pkg::BYTE_RESET;
      wlane_reg  <= 1'b0;
      bresp_reg  <= arw_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= arw_pkg::RESP_OKAY;
      dbg_reg    <= 1'b0;
      stage_reg  <= arw_pkg::BYTE_RESET;
      result_reg <= arw_pkg::WORD_RESET;
      acc_reg    <= arw_pkg::WORD_RESET;
      cnt_reg    <= 7'h00;
      winlo_reg  <= arw_pkg::WORD_RESET;
      winhi_reg  <= arw_pkg::WORD_RESET;
      mode_reg   <= 3'h0;
      flags_reg  <= 2'b00;
      mask_reg   <= 2'b00;
      irq_reg    <= 1'b0;
      run_reg    <= 1'b0;
    end
    else
    begin
      wst_reg    <= wst_next;
      rst_reg    <= rst_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wbyte_reg  <= wbyte_next;
      wlane_reg  <= wlane_next;
      bresp_reg  <= bresp_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      dbg_reg    <= dbg_next;
      stage_reg  <= stage_next;
      result_reg <= result_next;
      acc_reg    <= acc_next;
      cnt_reg    <= cnt_next;
      winlo_reg  <= winlo_next;
      winhi_reg  <= winhi_next;
      mode_reg   <= mode_next;
      flags_reg  <= flags_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      run_reg    <= run_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every bus output is a flop or a flop bit
  assign s_axi_awready = awrdy_reg;
  assign s_axi_wready  = wrdy_reg;
  assign s_axi_bvalid  = wst_reg[1];
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rst_reg[0];
  assign s_axi_rvalid  = rst_reg[2];
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign conv_enable   = run_reg;
  assign irq           = irq_reg;

endmodule // arw_regs

// *** verif/arw_regs_assertions.sv ***
// Checker for the result and window register block.
// Assumes it is bound to arw_regs and sees only its ports.
`timescale 1ns/1ps

module arw_regs_checker
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bus handshakes
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter side
  input  wire logic        cpu_halted,
  input  wire logic        conv_enable
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_run_free: assert property (!cpu_halted |=> conv_enable)
    else $error("converter stopped while cpu running");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_debug_run: cover property (cpu_halted && conv_enable);
endmodule // arw_regs_checker

// *** verif/arw_cpu_model.sv ***
// CPU side model: AXI4-Lite master with word tasks.
// Assumes the bench calls wr and rd one at a time.
`timescale 1ns/1ps

module arw_cpu_model
(
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [9:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [9:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // ****************
  // Bus cycles
  // ****************
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 48'h0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 13'h0;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~s_axi_araddr;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // arw_cpu_model

// *** verif/tb.sv ***
// Top bench of the converter result and window register block.
// Assumes the checker and CPU model files compile first.
`timescale 1ns/1ps

module tb;
  // ****************
  // Stimulus and checks
  // ****************
  localparam logic [7:0]  RST_IDX [8] = '{8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
  localparam logic [15:0] VALS [5] = '{16'h0050, 16'h0100, 16'h0150, 16'h0200, 16'h0250};
  logic                 aclk;
  logic                 aresetn;
  logic [9:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp, resp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  arw_pkg::arw_sample_t sample_in;
  logic                 cpu_halted, conv_enable, irq, exp_m;
  logic [15:0]          v;
  int                   fail_count, comparisons, cycles;

  arw_regs dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sample_in(sample_in), .cpu_halted(cpu_halted),
    .conv_enable(conv_enable), .irq(irq)
  );
  arw_cpu_model cpu
  (
    .aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    cpu.rd(idx, rd_data, resp);
    chk($sformatf("reg %h", idx), {8'h00, exp}, rd_data[15:0]);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    cpu.wr(idx, d, resp);
  endtask

  task automatic smp(input logic [9:0] c, input logic ov, input logic un, input logic lst);
    @(posedge aclk);
    sample_in <= {1'b1, ov, un, lst, c};
    @(posedge aclk);
    sample_in <= 14'h0000;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Cut a hang well past the expected run of under a thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    {aresetn, sample_in, cpu_halted, fail_count, comparisons, cycles} = 112'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RST_IDX[i]) rchk(RST_IDX[i], 8'h00);
    wreg(8'h0d, 8'ha5);
    rchk(8'h0d, 8'ha5);
    wreg(8'h14, 8'h33);
    rchk(8'h14, 8'h00);
    wreg(8'h12, 8'h00);
    wreg(8'h13, 8'h01);
    wreg(8'h14, 8'h00);
    wreg(8'h15, 8'h02);
    rchk(8'h12, 8'h00);
    rchk(8'h13, 8'h01);
    rchk(8'h14, 8'h00);
    rchk(8'h15, 8'h02);
    // Every mode against values below, on and between both limits
    for (int m = 0; m < 5; m++)
      foreach (VALS[k])
      begin
        v = VALS[k];
        case (m)
          1: exp_m = v < 16'h0100;
          2: exp_m = v > 16'h0200;
          3: exp_m = v > 16'h0100 && v < 16'h0200;
          4: exp_m = v < 16'h0100 || v > 16'h0200;
          default: exp_m = 1'b0;
        endcase
        wreg(8'h04, 8'(m));
        smp(v[9:0], 1'b0, 1'b0, 1'b1);
        rchk(8'h0b, {6'h00, exp_m, 1'b1});
        rchk(8'h10, v[7:0]);
        rchk(8'h11, v[15:8]);
        rchk(8'h0b, 8'h00);
      end
    smp(10'h050, 1'b0, 1'b0, 1'b1);
    wreg(8'h0b, 8'h00);
    rchk(8'h0b, 8'h03);
    wreg(8'h0b, 8'h02);
    rchk(8'h0b, 8'h01);
    wreg(8'h0a, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 16'h0001, {15'h0000, irq});
    wreg(8'h0b, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 16'h0000, {15'h0000, irq});
    smp(10'h050, 1'b0, 1'b0, 1'b1);
    wreg(8'h0a, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq", 16'h0000, {15'h0000, irq});
    wreg(8'h0b, 8'h03);
    wreg(8'h04, 8'h03);
    smp(10'h0f0, 1'b0, 1'b0, 1'b0);
    smp(10'h060, 1'b0, 1'b0, 1'b1);
    rchk(8'h0b, 8'h03);
    rchk(8'h10, 8'h50);
    rchk(8'h11, 8'h01);
    smp(10'h000, 1'b1, 1'b0, 1'b1);
    rchk(8'h10, 8'hff);
    rchk(8'h11, 8'h03);
    smp(10'h155, 1'b0, 1'b1, 1'b1);
    rchk(8'h10, 8'h00);
    rchk(8'h11, 8'h00);
    for (int i = 0; i < 64; i++)
      smp(10'h3ff, 1'b0, 1'b0, i == 63);
    rchk(8'h10, 8'hc0);
    rchk(8'h11, 8'hff);
    cpu_halted <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("conv_enable", 16'h0000, {15'h0000, conv_enable});
    smp(10'h123, 1'b0, 1'b0, 1'b1);
    rchk(8'h0b, 8'h00);
    wreg(8'h0c, 8'h01);
    repeat (2) @(posedge aclk);
    chk("conv_enable", 16'h0001, {15'h0000, conv_enable});
    rchk(8'h0c, 8'h01);
    smp(10'h123, 1'b0, 1'b0, 1'b1);
    rchk(8'h0b, 8'h03);
    rchk(8'h10, 8'h23);
    cpu_halted <= 1'b0;
    cpu.wr(8'h3f, 8'h11, resp);
    chk("bresp", {14'h0000, arw_pkg::RESP_SLVERR}, {14'h0000, resp});
    cpu.rd(8'h3f, rd_data, resp);
    chk("rresp", {14'h0000, arw_pkg::RESP_SLVERR}, {14'h0000, resp});
    print_verdict();
  end
endmodule // tb

bind arw_regs arw_regs_checker chk_i
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpu_halted(cpu_halted), .conv_enable(conv_enable)
);
